// ---- i2c_target_port.sv ----
// i2c target port of the accelerometer register interface
// Contract
// - serial port starts an i2c target transaction only while chip select is high
// - standard 100 kHz and fast 400 kHz transfers; bench master first runs 8 clocks per bit (3.125 MHz, above fast mode), then 250 clocks per bit (100 kHz)
// - single and multi byte writes and reads in one transaction
// - strap high: address 0x1D, bytes 0x3A write, 0x3B read
// - strap low: address 0x53, bytes 0xA6 write, 0xA7 read
// - write: address, register byte, data bytes all acknowledged by target
// - read: register written, repeated start, data returned until master nacks
`timescale 1ns/1ps
module i2c_target_port
   import i2c_target_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_cs,
   input  wire logic i_bus_id_strap_pin,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda,
   output logic      o_sda_oe,
   output logic      o_busy
);
   // ==========================================
   // input synchronisers
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic [1:0] cs_s;
   logic [1:0] strap_s;
   logic       scl_d;
   logic       sda_d;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_s   <= 2'h3;
         sda_s   <= 2'h3;
         cs_s    <= 2'h0;
         strap_s <= 2'h0;
         scl_d   <= 1'b1;
         sda_d   <= 1'b1;
      end else begin
         scl_s   <= {scl_s[0], i_scl};
         sda_s   <= {sda_s[0], i_sda};
         cs_s    <= {cs_s[0], i_cs};
         strap_s <= {strap_s[0], i_bus_id_strap_pin};
         scl_d   <= scl_s[1];
         sda_d   <= sda_s[1];
      end
   end

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [6:0] own_addr;

   assign scl      = scl_s[1];
   assign sda      = sda_s[1];
   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
   assign start_c  = cs_s[1] & scl & scl_d & sda_d & ~sda;
   assign stop_c   = scl & scl_d & ~sda_d & sda;
   assign own_addr = strap_s[1] ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;

   // ==========================================
   // link state machine
   link_state_t state;
   link_state_t next_state;
   logic [2:0]  bitc;
   logic [2:0]  next_bitc;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [7:0]  ptr;
   logic [7:0]  next_ptr;
   logic        have_reg;
   logic        next_have_reg;
   logic        rd_mode;
   logic        next_rd_mode;
   logic        sda_oe;
   logic        next_sda_oe;
   logic        sda_o;
   logic        next_sda_o;
   logic        busy;
   logic        next_busy;
   mem_req_t    req;
   logic [7:0]  rdata;

   i2c_reg_mem u_mem (
      .i_clk   (i_clk),
      .i_req   (req),
      .o_rdata (rdata)
   );

   // counter steps
   function automatic logic [7:0] step_ptr(input logic [7:0] v);
      return v + 8'h01;
   endfunction
   function automatic logic [2:0] step_bit(input logic [2:0] v);
      return v + 3'h1;
   endfunction

   always_comb begin
      next_state    = state;
      next_bitc     = bitc;
      next_shreg    = shreg;
      next_ptr      = ptr;
      next_have_reg = have_reg;
      next_rd_mode  = rd_mode;
      next_sda_oe   = sda_oe;
      next_sda_o    = sda_o;
      next_busy     = busy;
      req.we        = 1'b0;
      req.addr      = ptr;
      req.wdata     = shreg;
      if (start_c) begin
         next_state  = ST_ADDR;
         next_bitc   = 3'h0;
         next_sda_oe = 1'b0;
         next_busy   = 1'b1;
      end else if (stop_c) begin
         next_state  = ST_IDLE;
         next_sda_oe = 1'b0;
         next_busy   = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_sda_oe = 1'b0;
            end
            ST_ADDR, ST_WRX: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda};
                  next_bitc  = step_bit(bitc);
                  if (bitc == BIT_LAST) begin
                     next_state = (state == ST_ADDR) ? ST_AACK : ST_WACK;
                  end
               end
            end
            ST_AACK, ST_WACK: begin
               if (scl_fall && !sda_oe) begin
                  if (state == ST_WACK || shreg[7:1] == own_addr) begin
                     next_sda_oe = 1'b1;
                     next_sda_o  = 1'b0;
                     if (state == ST_AACK) begin
                        next_rd_mode = shreg[0];
                     end else if (!have_reg) begin
                        next_ptr      = shreg;
                        next_have_reg = 1'b1;
                     end else begin
                        req.we   = 1'b1;
                        next_ptr = step_ptr(ptr);
                     end
                  end else begin
                     next_state = ST_IDLE;
                     next_busy  = 1'b0;
                  end
               end else if (scl_fall) begin
                  next_bitc = 3'h0;
                  if (state == ST_AACK && rd_mode) begin
                     next_state  = ST_RTX;
                     next_shreg  = rdata;
                     next_sda_o  = rdata[7];
                     next_ptr    = step_ptr(ptr);
                  end else begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_WRX;
                     if (state == ST_AACK) begin
                        next_have_reg = 1'b0;
                     end
                  end
               end
            end
            ST_RTX: begin
               if (scl_fall) begin
                  next_bitc = step_bit(bitc);
                  if (bitc == BIT_LAST) begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_RACK;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_sda_o = shreg[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda) begin
                     next_state = ST_IDLE;
                     next_busy  = 1'b0;
                  end else begin
                     next_shreg = rdata;
                     next_ptr   = step_ptr(ptr);
                  end
               end else if (scl_fall) begin
                  next_state  = ST_RTX;
                  next_bitc   = 3'h0;
                  next_sda_oe = 1'b1;
                  next_sda_o  = shreg[7];
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state    <= ST_IDLE;
         bitc     <= 3'h0;
         shreg    <= 8'h00;
         ptr      <= PTR_RESET;
         have_reg <= 1'b0;
         rd_mode  <= 1'b0;
         sda_oe   <= 1'b0;
         sda_o    <= 1'b1;
         busy     <= 1'b0;
      end else begin
         state    <= next_state;
         bitc     <= next_bitc;
         shreg    <= next_shreg;
         ptr      <= next_ptr;
         have_reg <= next_have_reg;
         rd_mode  <= next_rd_mode;
         sda_oe   <= next_sda_oe;
         sda_o    <= next_sda_o;
         busy     <= next_busy;
      end
   end

   assign o_sda    = sda_o;
   assign o_sda_oe = sda_oe;
   assign o_busy   = busy;

   // ==========================================
   // assertions
   property p_ack_low;
      @(posedge i_clk) disable iff (!i_resetn)
         ((state == ST_AACK || state == ST_WACK) && sda_oe) |-> !sda_o;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not low");

   property p_idle_release;
      @(posedge i_clk) disable iff (!i_resetn)
         (state == ST_IDLE) |=> (!sda_oe || start_c);
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("sda driven idle");

   property p_stop_idle;
      @(posedge i_clk) disable iff (!i_resetn)
         stop_c && !start_c |=> state == ST_IDLE && !busy;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");

   property p_wr_step;
      @(posedge i_clk) disable iff (!i_resetn)
         req.we |=> ptr == $past(ptr) + 8'h01;
   endproperty
   a_wr_step: assert property (p_wr_step) else $error("pointer not stepped");

   property p_nack_end;
      @(posedge i_clk) disable iff (!i_resetn)
         (state == ST_RACK && scl_rise && sda && !start_c && !stop_c) |=> state == ST_IDLE;
   endproperty
   a_nack_end: assert property (p_nack_end) else $error("read went on after nack");

   property p_addr_match;
      @(posedge i_clk) disable iff (!i_resetn)
         (state == ST_AACK && scl_fall && !sda_oe && !start_c && !stop_c
          && shreg[7:1] != own_addr) |=> state == ST_IDLE;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("foreign address acked");

   property p_strap_low;
      @(posedge i_clk) disable iff (!i_resetn)
         (state == ST_AACK && scl_fall && !sda_oe && !start_c && !stop_c
          && !strap_s[1] && shreg[7:1] == 7'h53) |=> sda_oe && !sda_o;
   endproperty
   a_strap_low: assert property (p_strap_low) else $error("wrong low strap address");

   property p_unselected;
      @(posedge i_clk) disable iff (!i_resetn)
         (!cs_s[1] && state == ST_IDLE) |=> state == ST_IDLE;
   endproperty
   a_unselected: assert property (p_unselected) else $error("started while deselected");
endmodule

// ---- i2c_target_pkg.sv ----
// shared constants and types for the i2c target port
package i2c_target_pkg;

   // ==========================================
   // bus addresses and rates
   localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1D;
   localparam logic [6:0] ADDR_STRAP_LOW  = 7'h53;
   localparam int         CLK_HZ          = 25_000_000;
   localparam int         SCL_STD_HZ      = 100_000;
   localparam int         SCL_FAST_HZ     = 400_000;
   localparam int         FAST_PERIOD_CYC = CLK_HZ / SCL_FAST_HZ;

   // ==========================================
   // reset values and register memory
   localparam logic [7:0] PTR_RESET   = 8'h00;
   localparam int         MEM_DEPTH   = 256;
   localparam logic [2:0] BIT_LAST    = 3'h7;

   // ==========================================
   // link state
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b010,
      ST_WRX   = 3'b011,
      ST_WACK  = 3'b100,
      ST_RTX   = 3'b101,
      ST_RACK  = 3'b110
   } link_state_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

endpackage

// ---- i2c_reg_mem.sv ----
// register memory behind the i2c target port
`timescale 1ns/1ps
module i2c_reg_mem
   import i2c_target_pkg::*;
(
   input  wire logic       i_clk,
   input  wire mem_req_t   i_req,
   output logic [7:0]      o_rdata
);
   logic [7:0] mem [MEM_DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_req.we) begin
         mem[i_req.addr] <= i_req.wdata;
      end
      o_rdata <= mem[i_req.addr];
   end
endmodule

// ---- i2c_master_model.sv ----
// bus master model driving scl and pulling sda low
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   // ==========================================
   // scl phase length in clocks
   int half = 4;
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // ==========================================
   // start or repeated start
   task automatic start();
      tick(1);
      o_sda_oe <= 1'b0;
      tick(half);
      o_scl <= 1'b1;
      tick(half);
      o_sda_oe <= 1'b1;
      tick(half);
      o_scl <= 1'b0;
   endtask
   task automatic stop();
      tick(1);
      o_sda_oe <= 1'b1;
      tick(half);
      o_scl <= 1'b1;
      tick(half);
      o_sda_oe <= 1'b0;
      tick(half);
   endtask
   task automatic bit_x(input logic b, output logic s);
      tick(1);
      o_sda_oe <= ~b;
      tick(half - 1);
      o_scl <= 1'b1;
      tick(half);
      s = i_sda;
      o_scl <= 1'b0;
   endtask
   // byte out msb first, ack read back
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nack, s);
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the i2c target port
`timescale 1ns/1ps
module tb_top;
   import i2c_target_pkg::*;
   logic       clk, resetn, cs, strap, scl, m_oe, t_sda, t_oe, busy;
   wire logic  sda;
   int         err_count = 0;
   int         checks_done = 0;
   int         seed;
   int         ptr = 0;
   logic [7:0] ref_mem [int];
   assign sda = ~m_oe & (t_oe ? t_sda : 1'b1);
   i2c_target_port i_i2c_target_port (.i_clk(clk), .i_resetn(resetn), .i_cs(cs),
      .i_bus_id_strap_pin(strap), .i_scl(scl), .i_sda(sda), .o_sda(t_sda), .o_sda_oe(t_oe), .o_busy(busy));
   i2c_master_model i_i2c_master_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
   // ==========================================
   // checking and closing
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic own(input logic [7:0] b);
      return cs && (b[7:1] == (strap ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW));
   endfunction
   // ==========================================
   // transactions
   task automatic do_write(input logic [7:0] fb, input logic [7:0] rg, input int n);
      logic       ack;
      logic [7:0] d;
      i_i2c_master_model.start();
      i_i2c_master_model.wbyte(fb, ack);
      check("addr ack", {7'h00, ack}, {7'h00, own(fb)});
      check("busy", {7'h00, busy}, {7'h00, own(fb)});
      if (ack) begin
         i_i2c_master_model.wbyte(rg, ack);
         check("reg ack", {7'h00, ack}, 8'h01);
         ptr = rg;
         for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            i_i2c_master_model.wbyte(d, ack);
            check("data ack", {7'h00, ack}, 8'h01);
            ref_mem[ptr] = d;
            ptr = (ptr + 1) % 256;
         end
      end
      i_i2c_master_model.stop();
   endtask
   task automatic do_read(input logic [7:0] fb, input logic [7:0] rg, input int n, input bit rep);
      logic       ack;
      logic [7:0] d;
      i_i2c_master_model.start();
      i_i2c_master_model.wbyte(fb, ack);
      i_i2c_master_model.wbyte(rg, ack);
      ptr = rg;
      if (!rep) i_i2c_master_model.stop();
      i_i2c_master_model.start();
      i_i2c_master_model.wbyte(fb | 8'h01, ack);
      check("read addr ack", {7'h00, ack}, 8'h01);
      for (int k = 0; k < n; k++) begin
         i_i2c_master_model.rbyte(k == n - 1, d);
         check("read data", d, ref_mem[ptr]);
         ptr = (ptr + 1) % 256;
      end
      i_i2c_master_model.stop();
   endtask
   // ==========================================
   // clock, reset, sequence, watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #3_000_000;
      err_count++;
      end_sim();
   end
   initial begin
      logic [7:0] rg;
      resetn = 1'b0;
      cs = 1'b1;
      strap = 1'b1;
      seed = 32'h3ab2;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      do_write(8'h3A, 8'h10, 3);
      do_read(8'h3A, 8'h10, 3, 1'b1);
      do_write(8'h3A, 8'hFE, 3);
      do_read(8'h3A, 8'hFE, 3, 1'b1);
      do_read(8'h3A, 8'h11, 1, 1'b1);
      // strap low, stop then start read
      @(posedge clk);
      strap <= 1'b0;
      repeat (5) @(posedge clk);
      rg = 8'($random(seed));
      do_write(8'hA6, rg, 2);
      do_read(8'hA6, rg, 2, 1'b0);
      do_write(8'h3A, 8'h20, 1);
      cs <= 1'b0;
      repeat (5) @(posedge clk);
      do_write(8'hA6, 8'h20, 1);
      cs <= 1'b1;
      repeat (5) @(posedge clk);
      check("busy idle", {7'h00, busy}, 8'h00);
      i_i2c_master_model.half = 125;
      do_write(8'hA6, 8'h30, 2);
      do_read(8'hA6, 8'h30, 2, 1'b1);
      end_sim();
   end
endmodule
